// File: cost_map.svh
/*
 * Constants of the execution clock cost generator: clock figures per
 * column group, word transfer counts and bound trap spreads.
 * Assumes the including file needs the values as sized literals, 8-bit except the 2-bit spreads.
 */
`ifndef COST_MAP_SVH
`define COST_MAP_SVH

// ----------------------------------------------------------------
// Register and immediate forms
// ----------------------------------------------------------------
`define RR_ALL 8'h02
`define RI_AD 8'h04
`define RI_E 8'h02

// ----------------------------------------------------------------
// Memory forms: byte or even word, odd word
// ----------------------------------------------------------------
`define MR_B_AB 8'h10
`define MR_B_CD 8'h0d
`define MR_B_E 8'h07
`define MR_O_AB 8'h18
`define MR_O_CD 8'h15
`define MR_O_E 8'h0b
`define RM_B_AB 8'h0b
`define RM_B_CD 8'h0a
`define RM_B_E 8'h06
`define RM_O_AB 8'h0f
`define RM_O_CD 8'h0e
`define RM_O_E 8'h08
`define MI_B_AB 8'h12
`define MI_B_CD 8'h0f
`define MI_O_AB 8'h1a
`define MI_O_CD 8'h17
`define CI_B_AB 8'h0d
`define CI_B_CD 8'h0c
`define CI_O_AB 8'h11
`define CI_O_CD 8'h10

// ----------------------------------------------------------------
// Decimal string and adjust
// ----------------------------------------------------------------
`define DS_PER_AD 8'h13
`define DS_BASE_AD 8'h07
`define DSA_PER_E 8'h12
`define DSC_PER_E 8'h0e
`define DS_BASE_E 8'h02
`define NIB_AD 8'h03
`define NIB_E 8'h02
`define BYT_AD 8'h07
`define BYT_E 8'h04

// ----------------------------------------------------------------
// Branches
// ----------------------------------------------------------------
`define JC_HIT_AD 8'h0e
`define JC_HIT_E 8'h06
`define JC_FALL_AD 8'h04
`define JC_FALL_E 8'h03
`define LOOP_AD 8'h0d
`define LOOP_E 8'h06
`define LOOP_OUT_AD 8'h05
`define LOOP_OUT_E 8'h03
`define JMP_NEAR 8'h0d
`define JMP_SHORT 8'h0c
`define JMP_REG 8'h0b
`define JMP_FAR 8'h0f
`define JMP_E 8'h07

// ----------------------------------------------------------------
// Traps, calls, bound check
// ----------------------------------------------------------------
`define TRAP_O_AD 8'h32
`define TRAP_O_E 8'h18
`define TRAP_V_AD 8'h26
`define TRAP_V_E 8'h12
`define OVT_O_AD 8'h34
`define OVT_O_E 8'h1a
`define OVT_V_AD 8'h28
`define OVT_V_E 8'h14
`define OVT_CLR 8'h03
`define CALN_O_AD 8'h14
`define CALN_O_E 8'h09
`define CALN_V_AD 8'h10
`define CALN_V_E 8'h07
`define CALF_O_AD 8'h1d
`define CALF_O_E 8'h0d
`define CALF_V_AD 8'h15
`define CALF_V_E 8'h09
`define CHK_O_CD 8'h19
`define CHK_O_E 8'h0e
`define CHK_V_AB 8'h12
`define CHK_V_CD 8'h11
`define CHK_V_E 8'h0c
`define CHT_O_AB 8'h49
`define CHT_O_CD 8'h48
`define CHT_O_E 8'h1e
`define CHT_V_AB 8'h35
`define CHT_V_CD 8'h34
`define CHT_SPREAD 2'h3
`define CHT_SPREAD_E 2'h2

// ----------------------------------------------------------------
// Bit clear, block compare, divide
// ----------------------------------------------------------------
`define BCL_REG_AD 8'h05
`define BCL_REG_E 8'h04
`define BCL_O_CD 8'h13
`define BCL_O_E 8'h0d
`define BCL_V_E 8'h09
`define BLK_BASE 8'h07
`define BLK_PER_OO 8'h16
`define BLK_PER_OE 8'h12
`define BLK_E_B 8'h0c
`define BLK_E_OO 8'h10
`define DIV_B_AD 8'h13
`define DIV_B_E 8'h0b
`define DIV_W_E 8'h13

// ----------------------------------------------------------------
// Word transfer counts
// ----------------------------------------------------------------
`define XF_ONE 8'h01
`define XF_TWO 8'h02
`define XF_TRAP 8'h05
`define XF_CHT 8'h07

`endif

// File: cost_pkg.sv
/*
 * Types of the execution clock cost generator.
 * Assumes nothing of its surroundings.
 */
package cost_pkg;

	typedef enum logic [2:0] {
		COL_A = 3'h0,
		COL_B = 3'h1,
		COL_C = 3'h2,
		COL_D = 3'h3,
		COL_E = 3'h4
	} column_t;

	typedef enum logic [1:0] {
		FORM_NEAR = 2'h0,
		FORM_SHORT = 2'h1,
		FORM_REG = 2'h2,
		FORM_FAR = 2'h3
	} form_t;

	typedef enum logic [4:0] {
		OP_ALU_RR = 5'h00,
		OP_ALU_MR = 5'h01,
		OP_ALU_RM = 5'h02,
		OP_ALU_RI = 5'h03,
		OP_ALU_MI = 5'h04,
		OP_CMP_MI = 5'h05,
		OP_DEC_ADD = 5'h06,
		OP_DEC_CMP = 5'h07,
		OP_NIB_ADJ = 5'h08,
		OP_BYTE_ADJ = 5'h09,
		OP_JC_FLAG = 5'h0a,
		OP_JC_CTZ = 5'h0b,
		OP_LPNZ = 5'h0c,
		OP_LPNZ_ZSET = 5'h0d,
		OP_LPNZ_ZCLR = 5'h0e,
		OP_JUMP = 5'h0f,
		OP_SW_TRAP = 5'h10,
		OP_OV_TRAP = 5'h11,
		OP_CALL_NEAR = 5'h12,
		OP_CALL_FAR = 5'h13,
		OP_BOUND = 5'h14,
		OP_BIT_CLR = 5'h15,
		OP_BLK_CMP = 5'h16,
		OP_UDIV = 5'h17
	} op_class_t;

endpackage : cost_pkg

// File: cost_if.sv
/*
 * Carrier between the cost generator pipeline stages.
 * Assumes one clock for producer and consumer.
 */
`timescale 1ns/1ps
`default_nettype none

interface cost_if #(parameter int CNT_W = 8, parameter int WAIT_W = 4);
	logic valid;
	logic [15:0] clocks;
	logic [7:0] per;
	logic dec;
	logic [CNT_W-1:0] count;
	logic [15:0] xfers;
	logic odd;
	logic [1:0] spread;
	logic [WAIT_W-1:0] waits;

	modport src (output valid, clocks, per, dec, count, xfers, odd, spread, waits);
	modport dst (input valid, clocks, per, dec, count, xfers, odd, spread, waits);
endinterface : cost_if

`default_nettype wire

// File: cost_scaler.sv
/*
 * Second stage: clocks = base + per * count - dec, registered.
 * Assumes a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module cost_scaler (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Stages
	cost_if.dst up,
	cost_if.src dn
);
	logic [15:0] prod;

	assign prod = 16'(up.per * up.count);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			dn.valid <= 1'b0;
		end else begin
			dn.valid <= up.valid;
		end
	end

	always_ff @(posedge i_clk) begin
		dn.clocks <= up.clocks + prod - {15'h0000, up.dec};
		dn.per <= up.per;
		dn.dec <= up.dec;
		dn.count <= up.count;
		dn.xfers <= up.xfers;
		dn.odd <= up.odd;
		dn.spread <= up.spread;
		dn.waits <= up.waits;
	end
endmodule : cost_scaler

`default_nettype wire

// File: wait_adder.sv
/*
 * Third stage: adds word transfers times wait states, doubled when odd.
 * Assumes a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module wait_adder (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Stage in
	cost_if.dst up,
	// Result
	output logic o_valid,
	output logic [15:0] o_clocks,
	output logic [15:0] o_xfers,
	output logic [1:0] o_spread
);
	logic [15:0] extra;

	assign extra = 16'(up.xfers * up.waits);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_valid <= 1'b0;
		end else begin
			o_valid <= up.valid;
		end
	end

	// Zero waits leave the base cost untouched
	always_ff @(posedge i_clk) begin
		o_clocks <= up.clocks + (up.odd ? 16'(extra << 1) : extra);
		o_xfers <= up.xfers;
		o_spread <= up.spread;
	end
endmodule : wait_adder

`default_nettype wire

// File: exec_clock_cost_lookup.sv
/*
 * Execution clock cost generator: from instruction class, form, width,
 * parity, outcome and count it returns execution clocks and word
 * transfers for one of five core columns.
 * Assumes requests synchronous to i_clk; answer 4 cycles later.
 */
// Notes on behaviour
// - Register-register AND, add, add-with-carry cost 2 on all columns
// - Memory-destination byte op: 16 A/B, 13 C/D, 7 E
// - Odd word memory-destination: 24, 21, 11; even word as byte on B/D/E
// - Register-destination memory read: byte 11/10/6, odd word 15/14/8
// - Immediate into register or accumulator: 4 on A-D, 2 on E
// - Immediate into memory: byte 18/15/7, odd word 26/23/11
// - Decimal string add: 19m+7 on A-D, 18m+2 on E
// - Flag branch: taken 14 (E 6), fall through 4 (E 3)
// - Branch if count zero: nonzero 5 (E 3), zero 13 (E 6)
// - Decrement branch nonzero: nonzero 13 (E 6), zero 5 (E 3)
// - Flag-qualified decrement branch: hit 14 (E 6), else 5 (E 3)
// - Jumps: near 13, short 12, register 11, far 15; E 7
// - Software trap: 5 transfers; odd 50 (E 24), even 38 (E 18)
// - Overflow trap: set odd 52/26, even 40/20; clear 3
// - Near call odd 20/9 even 16/7; far call odd 29/13 even 21/9
// - Bound check pass: 2 transfers, 26/18; trap range 73 to 76 odd
// - Compare memory immediate: byte 13/12/6, odd word 17/16/8
// - Block compare: 7+14n bytes, 7+22n odd words; E 12n-1 or 16n-1
// - Costs exclude prefetch and waits; zero wait states assumed
// - Add transfers times waits; doubled for odd addresses
`timescale 1ns/1ps
`default_nettype none
`include "cost_map.svh"

module exec_clock_cost_lookup #(
	parameter int CNT_W = 8,
	parameter int WAIT_W = 4
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Request
	input wire logic i_valid,
	input wire cost_pkg::op_class_t i_op,
	input wire cost_pkg::column_t i_col,
	input wire cost_pkg::form_t i_form,
	input wire logic i_word,
	input wire logic i_odd,
	input wire logic i_odd_src,
	input wire logic i_cond,
	input wire logic i_flag,
	input wire logic [CNT_W-1:0] i_count,
	input wire logic [WAIT_W-1:0] i_wait,
	// Answer
	output logic o_valid,
	output logic [15:0] o_clocks,
	output logic [15:0] o_xfers,
	output logic [1:0] o_spread
);
	import cost_pkg::*;

	// ----------------------------------------------------------------
	// Column selection helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] pick(column_t c, logic [7:0] ab,
			logic [7:0] cd, logic [7:0] e);
		case (c)
			COL_A, COL_B: pick = ab;
			COL_C, COL_D: pick = cd;
			default: pick = e;
		endcase
	endfunction : pick

	function automatic logic [7:0] ad_e(column_t c, logic [7:0] ad,
			logic [7:0] e);
		ad_e = (c == COL_E) ? e : ad;
	endfunction : ad_e

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	cost_if #(.CNT_W(CNT_W), .WAIT_W(WAIT_W)) s1 ();
	cost_if #(.CNT_W(CNT_W), .WAIT_W(WAIT_W)) s2 ();

	logic bus8;
	logic hi;
	logic stk_odd;
	logic both_odd;
	logic one_odd;
	logic [7:0] base_d;
	logic [7:0] per_d;
	logic dec_d;
	logic [15:0] xf_d;
	logic [1:0] sp_d;
	logic odd_d;

	assign bus8 = (i_col == COL_A) || (i_col == COL_C);
	assign hi = i_word & (i_odd | bus8);
	assign stk_odd = i_odd | bus8;
	assign both_odd = i_word & ((i_odd & i_odd_src) | bus8);
	assign one_odd = i_word & (i_odd ^ i_odd_src);

	always_comb begin
		base_d = 8'h00;
		per_d = 8'h00;
		dec_d = 1'b0;
		xf_d = 16'h0000;
		sp_d = 2'h0;
		odd_d = hi;
		case (i_op)
			OP_ALU_RR: begin
				base_d = `RR_ALL;
			end
			OP_ALU_MR: begin
				xf_d = {8'h00, `XF_TWO};
				if (hi) begin
					base_d = pick(i_col, `MR_O_AB, `MR_O_CD, `MR_O_E);
				end else begin
					base_d = pick(i_col, `MR_B_AB, `MR_B_CD, `MR_B_E);
				end
			end
			OP_ALU_RM: begin
				xf_d = {8'h00, `XF_ONE};
				if (hi) begin
					base_d = pick(i_col, `RM_O_AB, `RM_O_CD, `RM_O_E);
				end else begin
					base_d = pick(i_col, `RM_B_AB, `RM_B_CD, `RM_B_E);
				end
			end
			OP_ALU_RI: begin
				base_d = ad_e(i_col, `RI_AD, `RI_E);
			end
			OP_ALU_MI: begin
				xf_d = {8'h00, `XF_TWO};
				if (hi) begin
					base_d = pick(i_col, `MI_O_AB, `MI_O_CD, `MR_O_E);
				end else begin
					base_d = pick(i_col, `MI_B_AB, `MI_B_CD, `MR_B_E);
				end
			end
			OP_CMP_MI: begin
				xf_d = {8'h00, `XF_ONE};
				if (hi) begin
					base_d = pick(i_col, `CI_O_AB, `CI_O_CD, `RM_O_E);
				end else begin
					base_d = pick(i_col, `CI_B_AB, `CI_B_CD, `RM_B_E);
				end
			end
			OP_DEC_ADD: begin
				base_d = ad_e(i_col, `DS_BASE_AD, `DS_BASE_E);
				per_d = ad_e(i_col, `DS_PER_AD, `DSA_PER_E);
			end
			OP_DEC_CMP: begin
				base_d = ad_e(i_col, `DS_BASE_AD, `DS_BASE_E);
				per_d = ad_e(i_col, `DS_PER_AD, `DSC_PER_E);
			end
			OP_NIB_ADJ: begin
				base_d = ad_e(i_col, `NIB_AD, `NIB_E);
			end
			OP_BYTE_ADJ: begin
				base_d = ad_e(i_col, `BYT_AD, `BYT_E);
			end
			OP_JC_FLAG: begin
				if (i_cond) begin
					base_d = ad_e(i_col, `JC_HIT_AD, `JC_HIT_E);
				end else begin
					base_d = ad_e(i_col, `JC_FALL_AD, `JC_FALL_E);
				end
			end
			OP_JC_CTZ: begin
				if (i_cond) begin
					base_d = ad_e(i_col, `LOOP_AD, `LOOP_E);
				end else begin
					base_d = ad_e(i_col, `LOOP_OUT_AD, `LOOP_OUT_E);
				end
			end
			OP_LPNZ: begin
				if (i_cond) begin
					base_d = ad_e(i_col, `LOOP_AD, `LOOP_E);
				end else begin
					base_d = ad_e(i_col, `LOOP_OUT_AD, `LOOP_OUT_E);
				end
			end
			OP_LPNZ_ZSET, OP_LPNZ_ZCLR: begin
				if (i_cond && (i_flag == (i_op == OP_LPNZ_ZSET))) begin
					base_d = ad_e(i_col, `JC_HIT_AD, `JC_HIT_E);
				end else begin
					base_d = ad_e(i_col, `LOOP_OUT_AD, `LOOP_OUT_E);
				end
			end
			OP_JUMP: begin
				case (i_form)
					FORM_NEAR: base_d = ad_e(i_col, `JMP_NEAR, `JMP_E);
					FORM_SHORT: base_d = ad_e(i_col, `JMP_SHORT, `JMP_E);
					FORM_REG: base_d = ad_e(i_col, `JMP_REG, `JMP_E);
					default: base_d = ad_e(i_col, `JMP_FAR, `JMP_E);
				endcase
			end
			OP_SW_TRAP: begin
				xf_d = {8'h00, `XF_TRAP};
				odd_d = stk_odd;
				if (stk_odd) begin
					base_d = ad_e(i_col, `TRAP_O_AD, `TRAP_O_E);
				end else begin
					base_d = ad_e(i_col, `TRAP_V_AD, `TRAP_V_E);
				end
			end
			OP_OV_TRAP: begin
				xf_d = {8'h00, `XF_TRAP};
				odd_d = stk_odd & i_cond;
				if (!i_cond) begin
					base_d = `OVT_CLR;
				end else if (stk_odd) begin
					base_d = ad_e(i_col, `OVT_O_AD, `OVT_O_E);
				end else begin
					base_d = ad_e(i_col, `OVT_V_AD, `OVT_V_E);
				end
			end
			OP_CALL_NEAR: begin
				xf_d = {8'h00, `XF_ONE};
				odd_d = stk_odd;
				if (stk_odd) begin
					base_d = ad_e(i_col, `CALN_O_AD, `CALN_O_E);
				end else begin
					base_d = ad_e(i_col, `CALN_V_AD, `CALN_V_E);
				end
			end
			OP_CALL_FAR: begin
				xf_d = {8'h00, `XF_TWO};
				odd_d = stk_odd;
				if (stk_odd) begin
					base_d = ad_e(i_col, `CALF_O_AD, `CALF_O_E);
				end else begin
					base_d = ad_e(i_col, `CALF_V_AD, `CALF_V_E);
				end
			end
			OP_BOUND: begin
				odd_d = stk_odd;
				if (i_cond) begin
					xf_d = {8'h00, `XF_CHT};
					sp_d = (i_col == COL_E) ? `CHT_SPREAD_E : `CHT_SPREAD;
					if (stk_odd) begin
						base_d = pick(i_col, `CHT_O_AB, `CHT_O_CD, `CHT_O_E);
					end else begin
						base_d = pick(i_col, `CHT_V_AB, `CHT_V_CD, `TRAP_O_E);
					end
				end else begin
					xf_d = {8'h00, `XF_TWO};
					if (stk_odd) begin
						base_d = pick(i_col, `MI_O_AB, `CHK_O_CD, `CHK_O_E);
					end else begin
						base_d = pick(i_col, `CHK_V_AB, `CHK_V_CD, `CHK_V_E);
					end
				end
			end
			OP_BIT_CLR: begin
				if (i_form == FORM_REG) begin
					base_d = ad_e(i_col, `BCL_REG_AD, `BCL_REG_E);
				end else if (hi) begin
					xf_d = {8'h00, `XF_TWO};
					base_d = pick(i_col, `BCL_O_CD + `OVT_CLR, `BCL_O_CD, `BCL_O_E);
				end else begin
					xf_d = i_word ? {8'h00, `XF_TWO} : 16'h0000;
					base_d = pick(i_col, `CI_B_AB + `NIB_E - 8'h01, `MR_O_E, `BCL_V_E);
				end
			end
			OP_BLK_CMP: begin
				xf_d = 16'({i_count, 1'b0});
				odd_d = both_odd | one_odd;
				if (i_col == COL_E) begin
					dec_d = 1'b1;
					if (both_odd) begin
						per_d = `BLK_E_OO;
					end else if (one_odd) begin
						per_d = `DSC_PER_E;
					end else begin
						per_d = `BLK_E_B;
					end
				end else begin
					base_d = `BLK_BASE;
					if (both_odd) begin
						per_d = `BLK_PER_OO;
					end else if (one_odd) begin
						per_d = `BLK_PER_OE;
					end else begin
						per_d = `DSC_PER_E;
					end
				end
			end
			OP_UDIV: begin
				if (i_word) begin
					base_d = ad_e(i_col, `CALF_V_AD + `NIB_AD + `OVT_CLR - 8'h02, `DIV_W_E);
				end else begin
					base_d = ad_e(i_col, `DIV_B_AD, `DIV_B_E);
				end
			end
			default: begin
				base_d = 8'h00;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// First pipeline register
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			s1.valid <= 1'b0;
		end else begin
			s1.valid <= i_valid;
		end
	end

	always_ff @(posedge i_clk) begin
		s1.clocks <= {8'h00, base_d};
		s1.per <= per_d;
		s1.dec <= dec_d;
		s1.count <= i_count;
		s1.xfers <= xf_d;
		s1.odd <= odd_d;
		s1.spread <= sp_d;
		s1.waits <= i_wait;
	end

	// ----------------------------------------------------------------
	// Repeat scaling and wait adjustment
	// ----------------------------------------------------------------
	logic w_valid;
	logic [15:0] w_clocks;
	logic [15:0] w_xfers;
	logic [1:0] w_spread;

	cost_scaler u_scaler (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.up(s1.dst),
		.dn(s2.src)
	);

	wait_adder u_wait (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.up(s2.dst),
		.o_valid(w_valid),
		.o_clocks(w_clocks),
		.o_xfers(w_xfers),
		.o_spread(w_spread)
	);

	// ----------------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_valid <= 1'b0;
			o_clocks <= 16'h0000;
			o_xfers <= 16'h0000;
			o_spread <= 2'h0;
		end else begin
			o_valid <= w_valid;
			o_clocks <= w_clocks;
			o_xfers <= w_xfers;
			o_spread <= w_spread;
		end
	end
endmodule : exec_clock_cost_lookup

`default_nettype wire

// File: exec_clock_cost_lookup_checker.sv
/* Port checker of the execution clock cost generator.
 * Assumes one clock, synchronous active-low reset, answer 4 cycles on. */
`timescale 1ns/1ps
`default_nettype none

module exec_clock_cost_checker #(
	parameter int CNT_W = 8,
	parameter int WAIT_W = 4
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Request
	input wire logic i_valid,
	input wire cost_pkg::op_class_t i_op,
	input wire cost_pkg::column_t i_col,
	input wire cost_pkg::form_t i_form,
	input wire logic i_word,
	input wire logic i_odd,
	input wire logic i_odd_src,
	input wire logic i_cond,
	input wire logic i_flag,
	input wire logic [CNT_W-1:0] i_count,
	input wire logic [WAIT_W-1:0] i_wait,
	// Answer
	input wire logic o_valid,
	input wire logic [15:0] o_clocks,
	input wire logic [15:0] o_xfers,
	input wire logic [1:0] o_spread
);
	import cost_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	chk_rr_cost: assert property (i_valid && i_op == OP_ALU_RR
		|-> ##4 o_valid && o_clocks == 16'h0002) else $error("register ALU cost wrong");
	chk_mr_byte: assert property (i_valid && i_op == OP_ALU_MR && !i_word && i_wait == 0
		|-> ##4 o_clocks == ($past(i_col, 4) == COL_E ? 16'h0007 :
		$past(i_col, 4) >= COL_C ? 16'h000d : 16'h0010)) else $error("byte op cost wrong");
	chk_imm_reg: assert property (i_valid && i_op == OP_ALU_RI
		|-> ##4 o_clocks == ($past(i_col, 4) == COL_E ? 16'h0002 : 16'h0004))
		else $error("immediate cost wrong");
	chk_wait_even: assert property (i_valid && i_op == OP_ALU_MR && i_col == COL_B
		&& i_word && !i_odd |-> ##4 o_clocks == 16'h0010 + 16'($past(i_wait, 4)) * 16'h0002)
		else $error("wait cost wrong");
	chk_word_narrow: assert property (i_valid && i_op == OP_ALU_MR && i_col == COL_A
		&& i_word && i_wait == 0 |-> ##4 o_clocks == 16'h0018) else $error("narrow word wrong");
	chk_dec_add: assert property (i_valid && i_op == OP_DEC_ADD && i_col != COL_E
		|-> ##4 o_clocks == 16'($past(i_count, 4)) * 16'h0013 + 16'h0007)
		else $error("decimal add cost wrong");
	chk_jump_kind: assert property (i_valid && i_op == OP_JUMP && i_col != COL_E
		|-> ##4 o_clocks == ($past(i_form, 4) == FORM_FAR ? 16'h000f :
		16'h000d - 16'($past(i_form, 4)))) else $error("jump cost wrong");
	chk_trap_xfers: assert property (i_valid && i_op == OP_SW_TRAP
		|-> ##4 o_xfers == 16'h0005 && o_spread == 2'h0) else $error("trap transfers wrong");
	chk_ovt_clear: assert property (i_valid && i_op == OP_OV_TRAP && !i_cond && i_wait == 0
		|-> ##4 o_clocks == 16'h0003) else $error("overflow clear cost wrong");
	chk_loop_exit: assert property (i_valid && i_op == OP_LPNZ && !i_cond
		|-> ##4 o_clocks == ($past(i_col, 4) == COL_E ? 16'h0003 : 16'h0005))
		else $error("loop exit cost wrong");
	chk_bound_spread: assert property (i_valid && i_op == OP_BOUND && i_cond
		|-> ##4 o_spread == ($past(i_col, 4) == COL_E ? 2'h2 : 2'h3))
		else $error("bound spread wrong");
endmodule : exec_clock_cost_checker

bind exec_clock_cost_lookup exec_clock_cost_checker #(.CNT_W(CNT_W), .WAIT_W(WAIT_W))
	u_exec_clock_cost_checker (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
	.i_op(i_op), .i_col(i_col), .i_form(i_form), .i_word(i_word), .i_odd(i_odd),
	.i_odd_src(i_odd_src), .i_cond(i_cond), .i_flag(i_flag), .i_count(i_count),
	.i_wait(i_wait), .o_valid(o_valid), .o_clocks(o_clocks), .o_xfers(o_xfers),
	.o_spread(o_spread));

`default_nettype wire

// File: test_exec_clock_cost_lookup.sv
/* Self-checking bench of the execution clock cost generator.
 * Assumes the port checker is bound from its own file. */
`timescale 1ns/1ps
`default_nettype none

module test_exec_clock_cost_lookup;
	import cost_pkg::*;
	logic i_clk, i_rst_n, i_valid, i_word, i_odd, i_odd_src, i_cond, i_flag;
	op_class_t i_op;
	column_t i_col;
	form_t i_form;
	logic [7:0] i_count;
	logic [3:0] i_wait;
	logic o_valid;
	logic [15:0] o_clocks, o_xfers;
	logic [1:0] o_spread;
	logic [33:0] exp_q[$];
	int n_fail = 0;
	int cmp_count = 0;

	exec_clock_cost_lookup u_exec_clock_cost_lookup (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_valid(i_valid), .i_op(i_op), .i_col(i_col), .i_form(i_form), .i_word(i_word),
		.i_odd(i_odd), .i_odd_src(i_odd_src), .i_cond(i_cond), .i_flag(i_flag),
		.i_count(i_count), .i_wait(i_wait), .o_valid(o_valid), .o_clocks(o_clocks),
		.o_xfers(o_xfers), .o_spread(o_spread));

	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	always @(negedge i_clk) begin
		if (i_rst_n === 1'b1 && o_valid === 1'b1) begin
			if (exp_q.size() == 0) check({o_spread, o_xfers, o_clocks}, '1);
			else check({o_spread, o_xfers, o_clocks}, exp_q.pop_front());
		end
	end

	// Bits: word, odd, second odd, outcome, zero flag
	task automatic send(input op_class_t op, input column_t col, input form_t f,
		input logic [4:0] b, input logic [7:0] n, input logic [3:0] w,
		input logic [15:0] c, input logic [15:0] x, input logic [1:0] s = 2'h0);
		@(posedge i_clk);
		i_valid <= 1'b1;
		i_op <= op;
		i_col <= col;
		i_form <= f;
		{i_word, i_odd, i_odd_src, i_cond, i_flag} <= b;
		i_count <= n;
		i_wait <= w;
		exp_q.push_back({s, x, c});
	endtask : send

	task automatic all5(input op_class_t op, input form_t f, input logic [4:0] b,
		input logic [7:0] n, input logic [39:0] c, input logic [15:0] x);
		for (int k = 0; k < 5; k++) begin
			send(op, column_t'(k), f, b, n, 4'h0, {8'h00, c[39-8*k -: 8]}, x);
		end
	endtask : all5

	task automatic drain();
		@(posedge i_clk);
		i_valid <= 1'b0;
		for (int k = 0; k < 20 && exp_q.size() != 0; k++) @(posedge i_clk);
		check(34'(exp_q.size()), 34'h0);
	endtask : drain

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_alu();
		all5(OP_ALU_RR, FORM_NEAR, 5'h00, 8'h00, 40'h0202020202, 16'h0000);
		all5(OP_ALU_MR, FORM_NEAR, 5'h00, 8'h00, 40'h10100d0d07, 16'h0002);
		all5(OP_ALU_MR, FORM_NEAR, 5'h18, 8'h00, 40'h181815150b, 16'h0002);
		all5(OP_ALU_MR, FORM_NEAR, 5'h10, 8'h00, 40'h1810150d07, 16'h0002);
		all5(OP_ALU_RM, FORM_NEAR, 5'h00, 8'h00, 40'h0b0b0a0a06, 16'h0001);
		all5(OP_ALU_RM, FORM_NEAR, 5'h18, 8'h00, 40'h0f0f0e0e08, 16'h0001);
		all5(OP_ALU_RI, FORM_NEAR, 5'h00, 8'h00, 40'h0404040402, 16'h0000);
		all5(OP_ALU_MI, FORM_NEAR, 5'h00, 8'h00, 40'h12120f0f07, 16'h0002);
		all5(OP_ALU_MI, FORM_NEAR, 5'h18, 8'h00, 40'h1a1a17170b, 16'h0002);
		all5(OP_CMP_MI, FORM_NEAR, 5'h00, 8'h00, 40'h0d0d0c0c06, 16'h0001);
		all5(OP_CMP_MI, FORM_NEAR, 5'h18, 8'h00, 40'h1111101008, 16'h0001);
		drain();
	endtask : t_alu

	task automatic t_dec();
		all5(OP_DEC_ADD, FORM_NEAR, 5'h00, 8'h03, 40'h4040404038, 16'h0000);
		all5(OP_DEC_ADD, FORM_NEAR, 5'h00, 8'h01, 40'h1a1a1a1a14, 16'h0000);
		all5(OP_DEC_CMP, FORM_NEAR, 5'h00, 8'h03, 40'h404040402c, 16'h0000);
		all5(OP_DEC_CMP, FORM_NEAR, 5'h00, 8'h00, 40'h0707070702, 16'h0000);
		all5(OP_NIB_ADJ, FORM_NEAR, 5'h00, 8'h00, 40'h0303030302, 16'h0000);
		all5(OP_BYTE_ADJ, FORM_NEAR, 5'h00, 8'h00, 40'h0707070704, 16'h0000);
		drain();
	endtask : t_dec

	task automatic t_branch();
		all5(OP_JC_FLAG, FORM_SHORT, 5'h02, 8'h00, 40'h0e0e0e0e06, 16'h0000);
		all5(OP_JC_FLAG, FORM_SHORT, 5'h00, 8'h00, 40'h0404040403, 16'h0000);
		all5(OP_JC_CTZ, FORM_SHORT, 5'h00, 8'h00, 40'h0505050503, 16'h0000);
		all5(OP_JC_CTZ, FORM_SHORT, 5'h02, 8'h00, 40'h0d0d0d0d06, 16'h0000);
		all5(OP_LPNZ, FORM_SHORT, 5'h02, 8'h00, 40'h0d0d0d0d06, 16'h0000);
		all5(OP_LPNZ, FORM_SHORT, 5'h00, 8'h00, 40'h0505050503, 16'h0000);
		all5(OP_LPNZ_ZSET, FORM_SHORT, 5'h03, 8'h00, 40'h0e0e0e0e06, 16'h0000);
		all5(OP_LPNZ_ZSET, FORM_SHORT, 5'h02, 8'h00, 40'h0505050503, 16'h0000);
		all5(OP_LPNZ_ZSET, FORM_SHORT, 5'h01, 8'h00, 40'h0505050503, 16'h0000);
		all5(OP_LPNZ_ZCLR, FORM_SHORT, 5'h02, 8'h00, 40'h0e0e0e0e06, 16'h0000);
		all5(OP_LPNZ_ZCLR, FORM_SHORT, 5'h03, 8'h00, 40'h0505050503, 16'h0000);
		all5(OP_JUMP, FORM_NEAR, 5'h00, 8'h00, 40'h0d0d0d0d07, 16'h0000);
		all5(OP_JUMP, FORM_SHORT, 5'h00, 8'h00, 40'h0c0c0c0c07, 16'h0000);
		all5(OP_JUMP, FORM_REG, 5'h00, 8'h00, 40'h0b0b0b0b07, 16'h0000);
		all5(OP_JUMP, FORM_FAR, 5'h00, 8'h00, 40'h0f0f0f0f07, 16'h0000);
		drain();
	endtask : t_branch

	task automatic t_stack();
		all5(OP_SW_TRAP, FORM_NEAR, 5'h08, 8'h00, 40'h3232323218, 16'h0005);
		all5(OP_SW_TRAP, FORM_NEAR, 5'h00, 8'h00, 40'h3226322612, 16'h0005);
		all5(OP_OV_TRAP, FORM_NEAR, 5'h0a, 8'h00, 40'h343434341a, 16'h0005);
		all5(OP_OV_TRAP, FORM_NEAR, 5'h02, 8'h00, 40'h3428342814, 16'h0005);
		all5(OP_OV_TRAP, FORM_NEAR, 5'h08, 8'h00, 40'h0303030303, 16'h0005);
		all5(OP_CALL_NEAR, FORM_NEAR, 5'h08, 8'h00, 40'h1414141409, 16'h0001);
		all5(OP_CALL_NEAR, FORM_NEAR, 5'h00, 8'h00, 40'h1410141007, 16'h0001);
		all5(OP_CALL_FAR, FORM_NEAR, 5'h08, 8'h00, 40'h1d1d1d1d0d, 16'h0002);
		all5(OP_CALL_FAR, FORM_NEAR, 5'h00, 8'h00, 40'h1d151d1509, 16'h0002);
		all5(OP_BOUND, FORM_NEAR, 5'h08, 8'h00, 40'h1a1a19190e, 16'h0002);
		all5(OP_BOUND, FORM_NEAR, 5'h00, 8'h00, 40'h1a1219110c, 16'h0002);
		send(OP_BOUND, COL_A, FORM_NEAR, 5'h0a, 8'h00, 4'h0, 16'h0049, 16'h0007, 2'h3);
		send(OP_BOUND, COL_C, FORM_NEAR, 5'h0a, 8'h00, 4'h0, 16'h0048, 16'h0007, 2'h3);
		send(OP_BOUND, COL_E, FORM_NEAR, 5'h0a, 8'h00, 4'h0, 16'h001e, 16'h0007, 2'h2);
		send(OP_BOUND, COL_B, FORM_NEAR, 5'h02, 8'h00, 4'h0, 16'h0035, 16'h0007, 2'h3);
		drain();
	endtask : t_stack

	task automatic t_misc();
		all5(OP_BIT_CLR, FORM_REG, 5'h00, 8'h00, 40'h0505050504, 16'h0000);
		all5(OP_BIT_CLR, FORM_NEAR, 5'h00, 8'h00, 40'h0e0e0b0b09, 16'h0000);
		all5(OP_BIT_CLR, FORM_NEAR, 5'h18, 8'h00, 40'h161613130d, 16'h0002);
		all5(OP_BLK_CMP, FORM_NEAR, 5'h00, 8'h03, 40'h3131313123, 16'h0006);
		all5(OP_BLK_CMP, FORM_NEAR, 5'h1c, 8'h02, 40'h333333331f, 16'h0004);
		all5(OP_UDIV, FORM_REG, 5'h00, 8'h00, 40'h131313130b, 16'h0000);
		all5(OP_UDIV, FORM_REG, 5'h10, 8'h00, 40'h1919191913, 16'h0000);
		drain();
	endtask : t_misc

	task automatic t_wait();
		send(OP_ALU_MR, COL_B, FORM_NEAR, 5'h10, 8'h00, 4'h3, 16'h0016, 16'h0002);
		send(OP_ALU_MR, COL_B, FORM_NEAR, 5'h18, 8'h00, 4'h3, 16'h0024, 16'h0002);
		send(OP_ALU_MR, COL_A, FORM_NEAR, 5'h10, 8'h00, 4'h1, 16'h001c, 16'h0002);
		send(OP_ALU_MR, COL_E, FORM_NEAR, 5'h10, 8'h00, 4'hf, 16'h0025, 16'h0002);
		send(OP_ALU_RR, COL_D, FORM_NEAR, 5'h00, 8'h00, 4'hf, 16'h0002, 16'h0000);
		send(OP_SW_TRAP, COL_D, FORM_NEAR, 5'h00, 8'h00, 4'h2, 16'h0030, 16'h0005);
		drain();
	endtask : t_wait

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict

	initial begin
		#1000000;
		n_fail++;
		print_verdict();
	end

	initial begin
		i_rst_n = 1'b0;
		{i_valid, i_word, i_odd, i_odd_src, i_cond, i_flag} = 6'h00;
		i_op = OP_ALU_RR;
		i_col = COL_A;
		i_form = FORM_NEAR;
		i_count = 8'h00;
		i_wait = 4'h0;
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_alu();
		t_dec();
		t_branch();
		t_stack();
		t_misc();
		t_wait();
		print_verdict();
	end
endmodule : test_exec_clock_cost_lookup

`default_nettype wire
